// ==== src/ptu_top.v ====
// Paging translation unit: 32-entry four-way translation cache, two-level
// walk with locked accessed/dirty updates, page fault reporting, V86 base.
// Assumes requester and memory port share clk; memory answers with mem_ack.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_regs.vh"

module ptu_top (
    input wire clk,
    input wire reset_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire req_valid,
    output reg req_ready,
    input wire [31:0] req_base,
    input wire [15:0] req_seg,
    input wire [31:0] req_offset,
    input wire req_v86,
    input wire req_write,
    input wire req_user,
    input wire req_dt,
    output reg rsp_valid,
    output reg rsp_fault,
    output reg [7:0] rsp_vector,
    output reg [15:0] rsp_error,
    output reg [31:0] rsp_phys,
    input wire ts_load,
    input wire [31:0] ts_dir_base,
    output reg mem_req,
    output reg mem_we,
    output reg mem_lock,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    input wire mem_ack,
    input wire [31:0] mem_rdata
);

    // ==========================================================
    // States
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_LOOK = 3'd1;
    localparam [2:0] S_PDE = 3'd2;
    localparam [2:0] S_PDEW = 3'd3;
    localparam [2:0] S_PTE = 3'd4;
    localparam [2:0] S_PTEW = 3'd5;

    // ==========================================================
    // Storage
    reg [2:0] state;
    reg pg_en;
    reg [31:0] dir_base;
    reg [31:0] fault_address_register;
    reg [15:0] last_error;
    reg [31:0] lin;
    reg acc_wr;
    reg acc_usr;
    reg [31:0] pde;
    reg [31:0] pte_new;
    reg [19:0] t_vpn [0:31];
    reg [19:0] t_frame [0:31];
    reg [1:0] t_age [0:31];
    reg [31:0] t_v;
    reg [31:0] t_d;
    reg [31:0] t_u;
    reg [31:0] t_rw;
    integer k;

    // Page protection check; supervisor bypasses page protection
    function prot_bad;
        input u;
        input rw;
        input usr;
        input wr;
        begin
            prot_bad = usr & (~u | (wr & ~rw));
        end
    endfunction

    // ==========================================================
    // Linear address formation for an incoming request
    reg [31:0] lin_in;
    reg v86_over;
    always @* begin
        if (req_v86) begin
            lin_in = {12'h000, req_seg, 4'h0} + req_offset;
        end else begin
            lin_in = req_base + req_offset;
        end
        v86_over = req_v86 && ({1'b0, req_offset} >= `PTU_V86_LIMIT);
    end

    // ==========================================================
    // Tag lookup within the selected set, and victim choice
    reg hit;
    reg [4:0] hit_idx;
    reg [4:0] vic_idx;
    reg vic_found;
    reg [4:0] ci;
    integer w;
    always @* begin
        hit = 1'b0;
        hit_idx = 5'd0;
        vic_idx = {lin[14:12], 2'd0};
        vic_found = 1'b0;
        ci = 5'd0;
        for (w = 0; w < 4; w = w + 1) begin
            ci = {lin[14:12], w[1:0]};
            // Full 20-bit tag kept so a hit never aliases
            if (t_v[ci] && t_vpn[ci] == lin[31:12]) begin
                hit = 1'b1;
                hit_idx = ci;
            end
        end
        // Invalid way first, otherwise the oldest way
        for (w = 3; w >= 0; w = w - 1) begin
            ci = {lin[14:12], w[1:0]};
            if (!t_v[ci] && !vic_found) begin
                vic_idx = ci;
                vic_found = 1'b1;
            end
        end
        for (w = 0; w < 4; w = w + 1) begin
            ci = {lin[14:12], w[1:0]};
            if (!vic_found && t_age[ci] == 2'd3) begin
                vic_idx = ci;
            end
        end
    end

    wire [31:0] pde_addr = {dir_base[31:12], lin[31:22], 2'b00};
    wire [31:0] pte_addr = {pde[31:12], lin[21:12], 2'b00};
    wire eff_u = pde[`PTU_E_US] & mem_rdata[`PTU_E_US];
    wire eff_rw = pde[`PTU_E_RW] & mem_rdata[`PTU_E_RW];
    wire hit_bad = prot_bad(t_u[hit_idx], t_rw[hit_idx], acc_usr, acc_wr);
    wire walk_bad = prot_bad(eff_u, eff_rw, acc_usr, acc_wr);
    wire mem_done = mem_req & mem_ack;

    // Register read mux
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address)
            `PTU_OFS_CTRL: rd_mux = {31'd0, pg_en};
            `PTU_OFS_DIRB: rd_mux = dir_base;
            `PTU_OFS_FADDR: rd_mux = fault_address_register;
            `PTU_OFS_STAT: rd_mux = {12'h000, ~req_ready, state, last_error};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Response helpers
    task finish_ok;
        input [31:0] phys;
        begin
            rsp_valid <= 1'b1;
            rsp_fault <= 1'b0;
            rsp_phys <= phys;
            mem_lock <= 1'b0;
            req_ready <= 1'b1;
            state <= S_IDLE;
        end
    endtask

    // Abort: no cache fill and no further bus cycle, so a retry is clean
    task finish_pf;
        input cause;
        begin
            rsp_valid <= 1'b1;
            rsp_fault <= 1'b1;
            rsp_vector <= `PTU_VEC_PF;
            rsp_error <= {13'h0000, acc_usr, acc_wr, cause};
            last_error <= {13'h0000, acc_usr, acc_wr, cause};
            fault_address_register <= lin;
            mem_lock <= 1'b0;
            req_ready <= 1'b1;
            state <= S_IDLE;
        end
    endtask

    // Mark one way most recent and age the younger ones
    task touch;
        input [4:0] idx;
        integer j;
        begin
            for (j = 0; j < 4; j = j + 1) begin
                if (t_age[{idx[4:2], j[1:0]}] < t_age[idx]) begin
                    t_age[{idx[4:2], j[1:0]}] <= t_age[{idx[4:2], j[1:0]}] + 2'd1;
                end
            end
            t_age[idx] <= 2'd0;
        end
    endtask

    // Fill the victim way from the final table entry
    task fill;
        input [31:0] e;
        begin
            t_v[vic_idx] <= 1'b1;
            t_vpn[vic_idx] <= lin[31:12];
            t_frame[vic_idx] <= e[31:12];
            t_d[vic_idx] <= e[`PTU_E_D];
            t_u[vic_idx] <= pde[`PTU_E_US] & e[`PTU_E_US];
            t_rw[vic_idx] <= pde[`PTU_E_RW] & e[`PTU_E_RW];
            touch(vic_idx);
        end
    endtask

    // ==========================================================
    // Main sequencer, register slave and cache maintenance
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            pg_en <= `PTU_RST_CTRL;
            dir_base <= `PTU_RST_DIRB;
            fault_address_register <= 32'h0000_0000;
            last_error <= 16'h0000;
            lin <= 32'h0000_0000;
            acc_wr <= 1'b0;
            acc_usr <= 1'b0;
            pde <= 32'h0000_0000;
            pte_new <= 32'h0000_0000;
            t_v <= 32'h0000_0000;
            t_d <= 32'h0000_0000;
            t_u <= 32'h0000_0000;
            t_rw <= 32'h0000_0000;
            for (k = 0; k < 32; k = k + 1) begin
                t_age[k] <= k[1:0];
            end
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_fault <= 1'b0;
            rsp_vector <= 8'h00;
            rsp_error <= 16'h0000;
            rsp_phys <= 32'h0000_0000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        lin <= lin_in;
                        acc_wr <= req_write;
                        acc_usr <= req_user & ~req_dt;
                        if (v86_over) begin
                            rsp_valid <= 1'b1;
                            rsp_fault <= 1'b1;
                            rsp_vector <= `PTU_VEC_GP;
                            rsp_error <= 16'h0000;
                        end else if (!pg_en) begin
                            rsp_valid <= 1'b1;
                            rsp_fault <= 1'b0;
                            rsp_phys <= lin_in;
                        end else begin
                            req_ready <= 1'b0;
                            state <= S_LOOK;
                        end
                    end
                end
                S_LOOK: begin
                    if (hit && hit_bad) begin
                        finish_pf(1'b1);
                    end else if (hit && !(acc_wr && !t_d[hit_idx])) begin
                        finish_ok({t_frame[hit_idx], lin[11:0]});
                        touch(hit_idx);
                    end else begin
                        // Miss, or first write to a clean page: walk
                        if (hit) begin
                            t_v[hit_idx] <= 1'b0;
                        end
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_lock <= 1'b1;
                        mem_addr <= pde_addr;
                        state <= S_PDE;
                    end
                end
                S_PDE: begin
                    if (mem_done) begin
                        pde <= mem_rdata;
                        if (!mem_rdata[`PTU_E_P]) begin
                            mem_req <= 1'b0;
                            finish_pf(1'b0);
                        end else if (!mem_rdata[`PTU_E_A]) begin
                            mem_we <= 1'b1;
                            mem_wdata <= mem_rdata | (32'd1 << `PTU_E_A);
                            state <= S_PDEW;
                        end else begin
                            mem_addr <= {mem_rdata[31:12], lin[21:12], 2'b00};
                            state <= S_PTE;
                        end
                    end
                end
                S_PDEW: begin
                    if (mem_done) begin
                        mem_we <= 1'b0;
                        mem_addr <= pte_addr;
                        state <= S_PTE;
                    end
                end
                S_PTE: begin
                    if (mem_done) begin
                        pte_new <= mem_rdata | (32'd1 << `PTU_E_A)
                            | ({31'd0, acc_wr} << `PTU_E_D);
                        if (!mem_rdata[`PTU_E_P]) begin
                            mem_req <= 1'b0;
                            finish_pf(1'b0);
                        end else if (walk_bad) begin
                            mem_req <= 1'b0;
                            finish_pf(1'b1);
                        end else if (!mem_rdata[`PTU_E_A] || (acc_wr && !mem_rdata[`PTU_E_D])) begin
                            mem_we <= 1'b1;
                            mem_wdata <= mem_rdata | (32'd1 << `PTU_E_A)
                                | ({31'd0, acc_wr} << `PTU_E_D);
                            state <= S_PTEW;
                        end else begin
                            mem_req <= 1'b0;
                            fill(mem_rdata);
                            finish_ok({mem_rdata[31:12], lin[11:0]});
                        end
                    end
                end
                S_PTEW: begin
                    if (mem_done) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        fill(pte_new);
                        finish_ok({pte_new[31:12], lin[11:0]});
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase

            // Avalon slave: one wait cycle, then the access completes
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= rd_mux;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            if (avs_write && !avs_waitrequest) begin
                if (avs_address == `PTU_OFS_CTRL) begin
                    pg_en <= avs_writedata[`PTU_CTRL_PG_BIT];
                end
                if (avs_address == `PTU_OFS_DIRB) begin
                    dir_base <= {avs_writedata[31:12], 12'h000};
                    t_v <= 32'h0000_0000;
                end
            end
            // Task switch wins over a same-cycle register write
            if (ts_load) begin
                dir_base <= {ts_dir_base[31:12], 12'h000};
                t_v <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// ==== src/ptu_regs.vh ====
// Constants of the paging translation unit: register offsets, entry
// fields, error code layout, vectors and reset values.
// Assumes inclusion by bare name from the unit's source file.
`ifndef PTU_REGS_VH
`define PTU_REGS_VH

// ==========================================================
// Register byte offsets on the Avalon slave
`define PTU_OFS_CTRL 4'h0
`define PTU_OFS_DIRB 4'h4
`define PTU_OFS_FADDR 4'h8
`define PTU_OFS_STAT 4'hC

// ==========================================================
// Control and reset values
`define PTU_CTRL_PG_BIT 0
`define PTU_RST_CTRL 1'b0
`define PTU_RST_DIRB 32'h0000_0000

// ==========================================================
// Directory and table entry fields
`define PTU_E_P 0
`define PTU_E_RW 1
`define PTU_E_US 2
`define PTU_E_A 5
`define PTU_E_D 6

// ==========================================================
// Error code fields and exception vectors
`define PTU_EC_P 0
`define PTU_EC_WR 1
`define PTU_EC_US 2
`define PTU_VEC_PF 8'h0E
`define PTU_VEC_GP 8'h0D

// ==========================================================
// V86 offset limit: offsets at or above this fault
`define PTU_V86_LIMIT 33'h0_0001_0000

`endif

// ==== testbench/ptu_mem_model.sv ====
// Memory partner of the unit: a word array serving table reads and updates.
// Assumes one cycle at a time, with mem_req held until mem_ack.
`timescale 1ns/1ps
`default_nettype none
module ptu_mem_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    // ==========================================
    // Storage and answer timing
    logic [31:0] mem [0:4095];
    logic [3:0] wait_cnt;
    // Ack after none or five waits; data flips outside ack so stale reads show
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= 32'hFFFF_FFFF;
        end else if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[13:2]];
            if (mem_we) begin
                mem[mem_addr[13:2]] <= mem_wdata;
            end
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/ptu_top_asserts.sv ====
// Checker for the translation unit, watching only its ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module ptu_top_asserts (
    input wire clk,
    input wire reset_n,
    input wire req_valid,
    input wire req_ready,
    input wire [31:0] req_base,
    input wire [15:0] req_seg,
    input wire [31:0] req_offset,
    input wire req_v86,
    input wire req_write,
    input wire req_user,
    input wire req_dt,
    input wire rsp_valid,
    input wire rsp_fault,
    input wire [7:0] rsp_vector,
    input wire [15:0] rsp_error,
    input wire [31:0] rsp_phys,
    input wire mem_req,
    input wire mem_we,
    input wire mem_lock,
    input wire [31:0] mem_addr,
    input wire mem_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // Copy of the taken request, so answers can be tied to their cause
    logic [31:0] lin;
    logic lw;
    logic lu;
    logic lim;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lin <= 32'h0;
            lw <= 1'b0;
            lu <= 1'b0;
            lim <= 1'b0;
        end else if (req_valid && req_ready) begin
            lin <= req_v86 ? {12'h0, req_seg, 4'h0} + req_offset : req_base + req_offset;
            lw <= req_write;
            lu <= req_user && !req_dt;
            lim <= req_v86 && (req_offset >= 32'h0001_0000);
        end
    end
    // ==========================================
    // Properties
    a_limit_fault: assert property (req_valid && req_ready && req_v86 &&
        req_offset >= 32'h0001_0000 |=> rsp_valid && rsp_fault && rsp_vector == 8'h0D)
        else $error("v86 offset limit did not fault");
    a_fault_vec: assert property (rsp_valid && rsp_fault && !lim |-> rsp_vector == 8'h0E)
        else $error("page fault vector wrong");
    a_err_priv: assert property (rsp_valid && rsp_fault && !lim |-> rsp_error[2] == lu)
        else $error("error privilege bit wrong");
    a_err_dir: assert property (rsp_valid && rsp_fault && !lim |-> rsp_error[1] == lw)
        else $error("error direction bit wrong");
    a_err_upper: assert property (rsp_valid && rsp_fault |-> rsp_error[15:3] == 13'h0)
        else $error("error code upper bits set");
    a_phys_offset: assert property (rsp_valid && !rsp_fault |-> rsp_phys[11:0] == lin[11:0])
        else $error("physical offset differs from linear");
    a_lock_walk: assert property (mem_req && mem_we |-> mem_lock)
        else $error("entry update not locked");
    a_mem_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request dropped before ack");
    a_ready_back: assert property (rsp_valid |=> req_ready)
        else $error("requester still stalled after answer");
    c_walk: cover property (mem_req && mem_we && mem_ack);
    c_page_fault: cover property (rsp_valid && rsp_fault && rsp_vector == 8'h0E);
    c_limit: cover property (rsp_valid && rsp_fault && rsp_vector == 8'h0D);
endmodule
bind ptu_top ptu_top_asserts ptu_top_asserts_inst (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_base(req_base), .req_seg(req_seg),
    .req_offset(req_offset), .req_v86(req_v86), .req_write(req_write), .req_user(req_user),
    .req_dt(req_dt), .rsp_valid(rsp_valid), .rsp_fault(rsp_fault), .rsp_vector(rsp_vector),
    .rsp_error(rsp_error), .rsp_phys(rsp_phys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_ack(mem_ack));
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench: register and request tasks drive the unit.
// Assumes the memory partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic req_valid = 1'b0;
    logic [31:0] req_base = 32'h0;
    logic [15:0] req_seg = 16'h0;
    logic [31:0] req_offset = 32'h0;
    logic req_v86 = 1'b0;
    logic req_write = 1'b0;
    logic req_user = 1'b0;
    logic req_dt = 1'b0;
    logic ts_load = 1'b0;
    logic [31:0] ts_dir_base = 32'h0;
    logic slow = 1'b0;
    wire [31:0] avs_readdata, rsp_phys, mem_addr, mem_wdata, mem_rdata;
    wire avs_waitrequest, req_ready, rsp_valid, rsp_fault, mem_req, mem_we, mem_lock, mem_ack;
    wire [7:0] rsp_vector;
    wire [15:0] rsp_error;
    logic [31:0] rd;
    int n_fail = 0;
    int cmp_count = 0;
    int n_mem = 0;
    int m0;
    int cyc = 0;
    ptu_top ptu_top_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .req_valid(req_valid), .req_ready(req_ready), .req_base(req_base), .req_seg(req_seg),
        .req_offset(req_offset), .req_v86(req_v86), .req_write(req_write),
        .req_user(req_user), .req_dt(req_dt), .rsp_valid(rsp_valid), .rsp_fault(rsp_fault),
        .rsp_vector(rsp_vector), .rsp_error(rsp_error), .rsp_phys(rsp_phys),
        .ts_load(ts_load), .ts_dir_base(ts_dir_base), .mem_req(mem_req), .mem_we(mem_we),
        .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    ptu_mem_model mem_model_inst (.clk(clk), .reset_n(reset_n), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // ==========================================
    // Clock, completed memory cycles and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_req && mem_ack) n_mem <= n_mem + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Avalon access: held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // One translation; a zero vector means a clean answer is expected
    task automatic xl(input logic [31:0] b, input logic [15:0] s, input logic [31:0] o,
        input logic v, w, u, dt, input logic [31:0] ph, input logic [15:0] er,
        input logic [7:0] vec);
        @(posedge clk);
        {req_valid, req_base, req_seg, req_offset} <= {1'b1, b, s, o};
        {req_v86, req_write, req_user, req_dt} <= {v, w, u, dt};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
        chk("fault", rsp_fault, vec != 8'h0);
        if (vec == 8'h0) chk("phys", rsp_phys, ph);
        else chk("vector", rsp_vector, vec);
        if (vec != 8'h0) chk("error", rsp_error, er);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        for (int i = 0; i < 4096; i++) mem_model_inst.mem[i] = 32'h0;
        mem_model_inst.mem[12'h401] = 32'h0000_2007;
        mem_model_inst.mem[12'h803] = 32'h0000_5007;
        mem_model_inst.mem[12'h805] = 32'h0000_6005;
        mem_model_inst.mem[12'hC00] = 32'h0000_3807;
        // Directory entry 0 at 0x3000 points back into its own page
        mem_model_inst.mem[12'hC01] = 32'h0000_A007;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl", rd, 32'h0);
        bus(1'b0, 4'h4, 32'h0);
        chk("dirb", rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        xl(32'h1234_0000, 16'h0, 32'h56, 0, 0, 1, 0, 32'h1234_0056, 16'h0, 8'h0);
        xl(32'h0, 16'h1234, 32'h10, 1, 0, 1, 0, 32'h0001_2350, 16'h0, 8'h0);
        xl(32'h0, 16'h1234, 32'hFFFF, 1, 0, 1, 0, 32'h0002_233F, 16'h0, 8'h0);
        xl(32'h0, 16'h1234, 32'h1_0000, 1, 1, 1, 0, 32'h0, 16'h0, 8'h0D);
        bus(1'b1, 4'h4, 32'h0000_1ABC);
        bus(1'b0, 4'h4, 32'h0);
        chk("dirb", rd, 32'h0000_1000);
        bus(1'b1, 4'h0, 32'h1);
        slow <= 1'b1;
        xl(32'h0, 16'h0, 32'h0040_3ABC, 0, 0, 1, 0, 32'h0000_5ABC, 16'h0, 8'h0);
        chk("pde", mem_model_inst.mem[12'h401], 32'h0000_2027);
        chk("pte", mem_model_inst.mem[12'h803], 32'h0000_5027);
        slow <= 1'b0;
        m0 = n_mem;
        xl(32'h0040_3000, 16'h0, 32'h10, 0, 0, 1, 0, 32'h0000_5010, 16'h0, 8'h0);
        chk("hit", n_mem, m0);
        xl(32'h0, 16'h0, 32'h0040_3004, 0, 1, 1, 0, 32'h0000_5004, 16'h0, 8'h0);
        chk("dirty", mem_model_inst.mem[12'h803], 32'h0000_5067);
        xl(32'h0, 16'h0, 32'h0040_4008, 0, 0, 1, 0, 32'h0, 16'h0004, 8'h0E);
        bus(1'b1, 4'h8, 32'hFFFF_FFFF);
        bus(1'b0, 4'h8, 32'h0);
        chk("fault_address", rd, 32'h0040_4008);
        // Fault left no cache entry, so the restarted access walks again
        mem_model_inst.mem[12'h804] = 32'h0000_8007;
        xl(32'h0, 16'h0, 32'h0040_4008, 0, 0, 1, 0, 32'h0000_8008, 16'h0, 8'h0);
        xl(32'h0, 16'h0, 32'h0040_5010, 0, 1, 1, 0, 32'h0, 16'h0007, 8'h0E);
        bus(1'b0, 4'hC, 32'h0);
        chk("stat", rd[15:0], 16'h0007);
        xl(32'h0, 16'h0, 32'h0040_6000, 0, 0, 1, 1, 32'h0, 16'h0000, 8'h0E);
        xl(32'h0, 16'h0, 32'h0040_5010, 0, 1, 0, 0, 32'h0000_6010, 16'h0, 8'h0);
        mem_model_inst.mem[12'h803] = 32'h0000_7007;
        bus(1'b1, 4'h4, 32'h0000_1000);
        xl(32'h0, 16'h0, 32'h0040_3123, 0, 0, 1, 0, 32'h0000_7123, 16'h0, 8'h0);
        @(posedge clk);
        ts_load <= 1'b1;
        ts_dir_base <= 32'h0000_3000;
        @(posedge clk);
        ts_load <= 1'b0;
        bus(1'b0, 4'h4, 32'h0);
        chk("dirb", rd, 32'h0000_3000);
        xl(32'h0, 16'h0100, 32'h42, 1, 0, 1, 0, 32'h0000_A042, 16'h0, 8'h0);
        final_report();
    end
endmodule
`default_nettype wire
